// *** can_bit_timing_power_modes_test.sv ***
// Self-checking bench for the CAN bit-timing and power-mode block.
// Assumes the bound checker and the node model on the bus pins.
`timescale 1ns/1ps
module can_bit_timing_power_modes_test;
  logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_d;
  logic [1:0]  cpu_mode;
  logic        rx_err_inc, rx_err_clr, busoff_event, can_rx, can_tx;
  logic [2:0]  mode_out;
  logic        sample_bit, irq, rd_e, drive;
  logic [15:0] pattern;
  logic [7:0]  b0, b1;
  int          miscompares, checks, cyc, errc, i, n;
  int          bitlen;
  int          txq[$];

  cbt_top cbt_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_mode(cpu_mode), .rx_err_inc(rx_err_inc),
    .rx_err_clr(rx_err_clr), .busoff_event(busoff_event), .can_rx(can_rx),
    .can_tx(can_tx), .mode_out(mode_out), .sample_bit(sample_bit), .irq(irq));
  cbt_node #(.BIT_CLKS(8)) cbt_node_inst (.clk(clk), .drive(drive), .pattern(pattern),
    .tx(can_tx), .rx(can_rx));

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(can_tx) txq.push_back(cyc);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_d, exp);
    chk(32'(rd_e), 32'h0);
  endtask : rd

  task automatic wmode(input logic [2:0] m);
    n = 0;
    while (mode_out !== m && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(mode_out), 32'(m));
  endtask : wmode

  task automatic tend(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask : tend

  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Whole run is a few hundred cycles; this bound of 20000 cycles leaves a wide margin
  initial
  begin
    #(40 * 20000);
    miscompares++;
    close_out();
  end

  initial
  begin
    {clk, rstn, psel, penable, pwrite, paddr, pwdata, cpu_mode} = '0;
    {rx_err_inc, rx_err_clr, busoff_event, drive, pattern, cyc, errc} = '0;
    ce = 1'b1;
    void'($urandom(32'h88CCBA64));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++) rd(12'(4 * i), 32'h0);
    chk(32'(mode_out), 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd_d[30:0], rd_e}, 32'h1);
    apb(1'b1, 12'h024, 32'hFFFFFFFF);
    chk(32'(rd_e), 32'h1);
    tend("reset");
    for (i = 0; i < 4; i++)
    begin
      b0 = {2'(i), 6'($urandom_range(0, 3))};
      b1 = {1'($urandom_range(0, 1)), 3'($urandom_range(1, 7)), 4'($urandom_range(1, 15))};
      apb(1'b1, cbt_pkg::OFS_BTR0, {24'($urandom), b0});
      apb(1'b1, cbt_pkg::OFS_BTR1, {24'($urandom), b1});
      rd(cbt_pkg::OFS_BTR0, {24'h0, b0});
      rd(cbt_pkg::OFS_BTR1, {24'h0, b1});
    end
    tend("timing");
    bitlen = 1 + (3 + 1) + (2 + 1);
    apb(1'b1, cbt_pkg::OFS_BTR0, 32'h0);
    apb(1'b1, cbt_pkg::OFS_BTR1, 32'h23);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h61);
    wmode(3'h1);
    txq.delete();
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h21);
    // Hold the dominant value across a whole bit so a transmit point surely takes it
    repeat (bitlen) @(posedge clk);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h61);
    repeat (3 * bitlen) @(posedge clk);
    chk(txq.size(), 2);
    // Own echo arrives late through the synchroniser: that bit stretches by the jump width plus one, here two quanta
    chk((txq[1] - txq[0]) % bitlen, 1);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h01);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, cbt_pkg::OFS_BTR1, {24'h0, 1'(i), 7'h23});
      drive <= 1'b1;
      repeat (4 * bitlen) @(posedge clk);
      chk(32'(sample_bit), 32'h0);
      drive <= 1'b0;
      repeat (4 * bitlen) @(posedge clk);
      chk(32'(sample_bit), 32'h1);
    end
    tend("bit");
    cpu_mode <= 2'h1;
    n = $urandom_range(1, 20);
    @(posedge clk);
    rx_err_inc <= 1'b1;
    repeat (n) @(posedge clk);
    rx_err_inc <= 1'b0;
    errc += n;
    rd(cbt_pkg::OFS_RXERR, 32'(errc));
    chk(32'(irq), 32'h0);
    apb(1'b1, cbt_pkg::OFS_IRQMSK, 32'h2);
    repeat (2) @(posedge clk);
    chk({irq, mode_out}, 32'h9);
    apb(1'b0, cbt_pkg::OFS_IRQST, 32'h0);
    chk(32'(rd_d[1]), 32'h1);
    apb(1'b0, cbt_pkg::OFS_IRQST, 32'h0);
    chk(32'(rd_d[1:0]), 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rx_err_clr <= 1'b1;
    @(posedge clk);
    rx_err_clr <= 1'b0;
    rd(cbt_pkg::OFS_RXERR, 32'h0);
    tend("errors");
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h05);
    wmode(3'h4);
    cpu_mode <= 2'h0;
    wmode(3'h1);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h03);
    wmode(3'h3);
    rd(cbt_pkg::OFS_STAT, 32'h13);
    cpu_mode <= 2'h2;
    wmode(3'h4);
    cpu_mode <= 2'h0;
    wmode(3'h3);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h09);
    wmode(3'h2);
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h01);
    wmode(3'h1);
    cpu_mode <= 2'h2;
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h00);
    wmode(3'h0);
    cpu_mode <= 2'h0;
    apb(1'b1, cbt_pkg::OFS_CTRL, 32'h11);
    wmode(3'h1);
    tend("modes");
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      busoff_event <= 1'b1;
      @(posedge clk);
      busoff_event <= 1'b0;
      rd(cbt_pkg::OFS_MISC, 32'(1 - i));
      apb(1'b1, cbt_pkg::OFS_MISC, 32'h0);
      rd(cbt_pkg::OFS_MISC, 32'(1 - i));
      apb(1'b1, cbt_pkg::OFS_MISC, 32'h1);
      rd(cbt_pkg::OFS_MISC, 32'h0);
      apb(1'b1, cbt_pkg::OFS_CTRL, 32'h01);
    end
    tend("busoff");
    close_out();
  end
endmodule : can_bit_timing_power_modes_test

// *** cbt_bit_timer.sv ***
// Bit-time sequencer: prescaler, quantum counter, sample and transmit points.
// Assumes a synchronised receive input and an active enable from the top.
`timescale 1ns/1ps
module cbt_bit_timer (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // Control
  input  wire logic                 run,
  input  wire cbt_pkg::cbt_timing_s tcfg,
  input  wire logic                 rx_in,
  // Events
  output cbt_pkg::cbt_bitev_s       ev
);
  logic [5:0] pre_ff;
  logic [4:0] tq_ff;
  logic [2:0] smp_ff;
  logic       prev_rx_ff;
  logic       tq_tick;
  logic       edge_fall;
  logic [4:0] seg1_end;
  logic [4:0] bit_end;
  logic [4:0] sjw_tq;
  logic [2:0] vote;

  assign tq_tick   = (pre_ff == tcfg.brp);
  // Sync segment is quantum 0; seg1 occupies 1..ts1+1
  assign seg1_end  = 5'(cbt_pkg::SYNC_TQ) + 5'(tcfg.ts1); // RULE8 RULE18
  assign bit_end   = seg1_end + 5'(tcfg.ts2) + 5'd1; // RULE18
  assign sjw_tq    = 5'(tcfg.sjw) + 5'd1; // RULE6
  assign edge_fall = prev_rx_ff & ~rx_in;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre_ff <= 6'h00;
    else if (ce)
      pre_ff <= (!run || tq_tick) ? 6'h00 : pre_ff + 6'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_rx_ff <= 1'b1;
    else if (ce)
      prev_rx_ff <= rx_in;
  end

  // Quantum counter with resynchronisation bounded by the jump width plus one quantum
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tq_ff <= 5'h00;
    else if (ce)
    begin
      if (!run)
        tq_ff <= 5'h00;
      else if (edge_fall && tq_ff != 5'h00 && tq_ff <= seg1_end)
        // Late edge: stretch seg1 by at most the jump width plus one quantum
        tq_ff <= (tq_ff > sjw_tq) ? tq_ff - sjw_tq : 5'h01; // RULE6
      else if (edge_fall && tq_ff > seg1_end && (bit_end - tq_ff) <= sjw_tq)
        tq_ff <= 5'h01; // RULE3
      else if (tq_tick)
        tq_ff <= (tq_ff >= bit_end - 5'd1) ? 5'h00 : tq_ff + 5'h01;
    end
  end

  // Three samples spaced one quantum ending at the sample point
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      smp_ff <= 3'b111;
    else if (ce && run && tq_tick)
      smp_ff <= {smp_ff[1:0], rx_in};
  end

  always_comb
  begin
    vote = {smp_ff[1:0], rx_in};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ev <= '0;
    else if (ce)
    begin
      ev.sync_point   <= run && tq_tick && tq_ff == 5'h00; // RULE3
      ev.tx_point     <= run && tq_tick && tq_ff == 5'h00; // RULE4
      ev.sample_point <= run && tq_tick && tq_ff == seg1_end; // RULE5
      ev.hard_edge    <= run && edge_fall && tq_ff == 5'h00; // RULE3
      if (run && tq_tick && tq_ff == seg1_end)
        ev.rx_bit <= tcfg.samp3 ? ((vote[0] & vote[1]) | (vote[0] & vote[2]) |
                                   (vote[1] & vote[2])) : rx_in; // RULE5
    end
  end
endmodule : cbt_bit_timer

// *** cbt_node.sv ***
// Other node on the shared bus: sends a bit pattern, wired-AND with our transmitter.
// Assumes a recessive pull-up when released and a fixed bit length in clocks.
`timescale 1ns/1ps
module cbt_node #(
  parameter int BIT_CLKS = 8
) (
  // Clock
  input  wire logic        clk,
  // Control from the bench
  input  wire logic        drive,
  input  wire logic [15:0] pattern,
  // Bus
  input  wire logic        tx,
  output logic             rx
);
  int         cnt = 0;
  logic [3:0] idx = 4'h0;
  always @(posedge clk)
  begin
    if (!drive || cnt == BIT_CLKS - 1)
    begin
      cnt <= 0;
      idx <= drive ? idx + 4'h1 : 4'h0;
    end
    else
      cnt <= cnt + 1;
  end
  // Dominant wins; a released node leaves the line to the pull-up
  assign rx = tx & (drive ? pattern[idx] : 1'b1);
endmodule : cbt_node

// *** cbt_pkg.sv ***
// Package for the bit-timing and power-mode block of a CAN controller.
// Assumes an APB master, a 25 MHz clock and an external CAN transceiver.
// Behaviour
// RULE1 - Hold bus-off, flag reads one, until request
// RULE2 - Receive error counter readable in status register; here it reads at OFS_RXERR, not OFS_STAT
// RULE3 - Sync segment is where edges are expected
// RULE4 - Transmit drives new bit at transmit point
// RULE5 - Sample at sample point, third of three
// RULE6 - Jump width programmable one to four quanta
// RULE7 - Segments and jump width from timing registers
// RULE8 - Segment fields hold length minus one; ts2 here holds the seg2 length itself
// RULE9 - Software picks standard-compliant timing values
// RULE10 - In run, sleep is only low-power option
// RULE11 - Wait with stop-in-wait forces power-down
// RULE12 - Leaving power-down returns to normal mode
// RULE13 - Wait without stop-in-wait keeps running, interrupts
// RULE14 - Stop forces power-down regardless of settings; here enable low gives disabled instead
// RULE15 - Enable low means disabled; setting gives normal
// RULE16 - Normal mode is in or out of initialization
// RULE17 - Writing one to hold flag requests recovery
// RULE18 - Sync one quantum; bit is one plus segments
package cbt_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_BTR0   = 12'h000;
  localparam logic [11:0] OFS_BTR1   = 12'h004;
  localparam logic [11:0] OFS_CTRL   = 12'h008;
  localparam logic [11:0] OFS_STAT   = 12'h00C;
  localparam logic [11:0] OFS_MISC   = 12'h010;
  localparam logic [11:0] OFS_RXERR  = 12'h014;
  localparam logic [11:0] OFS_IRQST  = 12'h018;
  localparam logic [11:0] OFS_IRQMSK = 12'h01C;

  // bit_timing_reg_zero fields
  localparam int BTR0_BRP_LSB = 0;
  localparam int BTR0_BRP_W   = 6;
  localparam int BTR0_SJW_LSB = 6;
  localparam int BTR0_SJW_W   = 2;
  // bit_timing_reg_one fields
  localparam int BTR1_TS1_LSB = 0;
  localparam int BTR1_TS1_W   = 4;
  localparam int BTR1_TS2_LSB = 4;
  localparam int BTR1_TS2_W   = 3;
  localparam int BTR1_SAMP    = 7;
  // Control fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_SLEEP_REQUEST   = 1;
  localparam int CTRL_STOP_IN_WAIT_CONTROL   = 2;
  localparam int CTRL_INITRQ  = 3;
  localparam int CTRL_BORSEL  = 4;
  localparam int CTRL_TXEN    = 5;
  localparam int CTRL_TXBIT   = 6;
  // Interrupt status bits
  localparam int IRQ_BUSOFF   = 0;
  localparam int IRQ_RXERR    = 1;
  localparam int IRQ_SAMPLE   = 2;
  localparam int IRQ_W        = 3;

  // Reset values and bus-off error count limit
  localparam logic [7:0] BTR0_RST = 8'h00;
  localparam logic [7:0] BTR1_RST = 8'h00;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] BUSOFF_LIMIT = 8'hFF;

  // Timing
  localparam int SYNC_TQ = 1;
  localparam int CLK_MHZ = 25;

  typedef enum logic [2:0] {
    CBT_DISABLED  = 3'b000,
    CBT_NORMAL    = 3'b001,
    CBT_INIT      = 3'b010,
    CBT_SLEEP     = 3'b011,
    CBT_POWERDOWN = 3'b100
  } cbt_mode_e;

  typedef enum logic [1:0] {
    CBT_CPU_RUN  = 2'b00,
    CBT_CPU_WAIT = 2'b01,
    CBT_CPU_STOP = 2'b10
  } cbt_cpu_e;

  typedef struct packed {
    logic [5:0] brp;
    logic [1:0] sjw;
    logic [3:0] ts1;
    logic [2:0] ts2;
    logic       samp3;
  } cbt_timing_s;

  typedef struct packed {
    logic tx_point;
    logic sample_point;
    logic sync_point;
    logic rx_bit;
    logic hard_edge;
  } cbt_bitev_s;

endpackage : cbt_pkg

// *** cbt_props.sv ***
// Checker for the bit-timing and power-mode block top.
// Sees only top-level ports; the bind at the foot attaches it to every top.
`timescale 1ns/1ps
module cbt_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Modes
  input wire logic [1:0]  cpu_mode,
  input wire logic [2:0]  mode_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_req;
    pready |-> $past(psel && penable) && psel && penable;
  endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("pready without access phase");
  property p_acc_bound;
    psel && penable |-> ##[0:1] pready;
  endproperty
  a_acc_bound: assert property (p_acc_bound) else $error("access not answered in time");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_idle_zero;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("prdata not zero when idle");
  property p_err_rd;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_rd: assert property (p_err_rd) else $error("refused read returned data");
  property p_stop_pd;
    (cpu_mode == 2'h2 && mode_out != 3'h0) [*3] |-> mode_out == 3'h4;
  endproperty
  a_stop_pd: assert property (p_stop_pd) else $error("stop did not power down");
  property p_pd_exit;
    $past(mode_out) == 3'h4 && mode_out != 3'h4 && mode_out != 3'h0 |-> mode_out == 3'h1;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not left to normal");
  property p_run_no_pd;
    cpu_mode == 2'h0 [*3] |-> mode_out != 3'h4;
  endproperty
  a_run_no_pd: assert property (p_run_no_pd) else $error("power-down while running");
  property p_pd_cause;
    mode_out == 3'h4 |-> $past(cpu_mode) != 2'h0 || $past(cpu_mode, 2) != 2'h0;
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("power-down without cpu cause");
  c_pd: cover property (mode_out == 3'h4);
  c_sleep: cover property (mode_out == 3'h3);
  c_err: cover property (pslverr);
endmodule : cbt_props

bind cbt_top cbt_props cbt_props_inst (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_mode(cpu_mode), .mode_out(mode_out));

// *** cbt_sync2.sv ***
// Two-stage synchroniser for the CAN receive pin.
// Assumes the pin is asynchronous to clk; idles recessive (1).
`timescale 1ns/1ps
module cbt_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else if (ce)
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : cbt_sync2

// *** cbt_top.sv ***
// Top of the CAN bit-timing and power-mode block with APB registers.
// Assumes an APB master on clk and a CAN transceiver on can_rx/can_tx.
`timescale 1ns/1ps
module cbt_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU state
  input  wire logic [1:0]  cpu_mode,
  // Error counter inputs from the protocol engine
  input  wire logic        rx_err_inc,
  input  wire logic        rx_err_clr,
  input  wire logic        busoff_event,
  // CAN pins
  input  wire logic        can_rx,
  output logic             can_tx,
  // Status and interrupt
  output logic [2:0]       mode_out,
  output logic             sample_bit,
  output logic             irq
);
  logic [7:0]  btr0_ff;
  logic [7:0]  btr1_ff;
  logic [6:0]  ctrl_ff;
  logic        busoff_hold_flag_ff;
  logic        busoff_ff;
  logic [7:0]  rx_error_count_ff;
  logic [cbt_pkg::IRQ_W-1:0] irq_st_ff;
  logic [cbt_pkg::IRQ_W-1:0] irq_msk_ff;
  logic        sleep_acknowledge_ff;
  cbt_pkg::cbt_mode_e mode_ff;
  cbt_pkg::cbt_mode_e nxt_mode;
  logic        can_tx_ff;
  logic        irq_ff;
  logic        sample_bit_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        rx_sync;
  logic        run_timer;
  logic        wr_acc;
  logic        rd_acc;
  logic [cbt_pkg::IRQ_W-1:0] irq_set;
  cbt_pkg::cbt_timing_s tcfg;
  cbt_pkg::cbt_bitev_s  bev;

  // Address decode used by both read and write paths
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == cbt_pkg::OFS_BTR0) || (a == cbt_pkg::OFS_BTR1) ||
              (a == cbt_pkg::OFS_CTRL) || (a == cbt_pkg::OFS_STAT) ||
              (a == cbt_pkg::OFS_MISC) || (a == cbt_pkg::OFS_RXERR) ||
              (a == cbt_pkg::OFS_IRQST) || (a == cbt_pkg::OFS_IRQMSK);
  endfunction : addr_ok

  // One wait state: the access phase completes on its second cycle
  assign wr_acc = psel && penable && pready_ff && pwrite;
  assign rd_acc = psel && penable && pready_ff && !pwrite;

  cbt_sync2 u_rx_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .din  (can_rx),
    .dout (rx_sync)
  );

  // Timing taken straight from the two bus timing registers
  always_comb
  begin
    tcfg.brp   = btr0_ff[cbt_pkg::BTR0_BRP_LSB +: cbt_pkg::BTR0_BRP_W]; // RULE7
    tcfg.sjw   = btr0_ff[cbt_pkg::BTR0_SJW_LSB +: cbt_pkg::BTR0_SJW_W]; // RULE7
    tcfg.ts1   = btr1_ff[cbt_pkg::BTR1_TS1_LSB +: cbt_pkg::BTR1_TS1_W]; // RULE7
    tcfg.ts2   = btr1_ff[cbt_pkg::BTR1_TS2_LSB +: cbt_pkg::BTR1_TS2_W]; // RULE7
    tcfg.samp3 = btr1_ff[cbt_pkg::BTR1_SAMP];
  end

  // Timer runs in normal mode only; no compliance check on values
  assign run_timer = (mode_ff == cbt_pkg::CBT_NORMAL); // RULE9

  cbt_bit_timer u_timer (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .run  (run_timer),
    .tcfg (tcfg),
    .rx_in(rx_sync),
    .ev   (bev)
  );

  // Mode selection; power-down dominates sleep and init
  always_comb
  begin
    nxt_mode = cbt_pkg::CBT_NORMAL;
    if (!ctrl_ff[cbt_pkg::CTRL_ENABLE])
      nxt_mode = cbt_pkg::CBT_DISABLED; // RULE15
    else if (cpu_mode == cbt_pkg::CBT_CPU_STOP)
      nxt_mode = cbt_pkg::CBT_POWERDOWN; // RULE14
    else if (cpu_mode == cbt_pkg::CBT_CPU_WAIT && ctrl_ff[cbt_pkg::CTRL_STOP_IN_WAIT_CONTROL])
      nxt_mode = cbt_pkg::CBT_POWERDOWN; // RULE11
    else if (mode_ff == cbt_pkg::CBT_POWERDOWN)
      nxt_mode = cbt_pkg::CBT_NORMAL; // RULE12
    else if (ctrl_ff[cbt_pkg::CTRL_SLEEP_REQUEST] && sleep_acknowledge_ff)
      nxt_mode = cbt_pkg::CBT_SLEEP; // RULE10 RULE13
    else if (ctrl_ff[cbt_pkg::CTRL_INITRQ])
      nxt_mode = cbt_pkg::CBT_INIT; // RULE16
    else
      nxt_mode = cbt_pkg::CBT_NORMAL; // RULE15 RULE16
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mode_ff <= cbt_pkg::CBT_DISABLED;
    else if (ce)
      mode_ff <= nxt_mode;
  end

  // Sleep is acknowledged at the next bit boundary, or at once in init mode
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sleep_acknowledge_ff <= 1'b0;
    else if (ce)
    begin
      if (!ctrl_ff[cbt_pkg::CTRL_SLEEP_REQUEST] || mode_ff == cbt_pkg::CBT_POWERDOWN ||
          mode_ff == cbt_pkg::CBT_DISABLED)
        sleep_acknowledge_ff <= 1'b0;
      else if (bev.sync_point || mode_ff == cbt_pkg::CBT_INIT)
        sleep_acknowledge_ff <= 1'b1; // RULE10
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      btr0_ff    <= cbt_pkg::BTR0_RST;
      btr1_ff    <= cbt_pkg::BTR1_RST;
      ctrl_ff    <= cbt_pkg::CTRL_RST;
      irq_msk_ff <= '0;
    end
    else if (ce && wr_acc)
    begin
      unique case (paddr)
        cbt_pkg::OFS_BTR0:   btr0_ff    <= pwdata[7:0]; // RULE7
        cbt_pkg::OFS_BTR1:   btr1_ff    <= pwdata[7:0]; // RULE7
        cbt_pkg::OFS_CTRL:   ctrl_ff    <= pwdata[6:0];
        cbt_pkg::OFS_IRQMSK: irq_msk_ff <= pwdata[cbt_pkg::IRQ_W-1:0];
        default:             ctrl_ff    <= ctrl_ff;
      endcase
    end
  end

  // Bus-off state and hold flag; a new bus-off wins over a clearing write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busoff_ff           <= 1'b0;
      busoff_hold_flag_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (busoff_event || rx_error_count_ff == cbt_pkg::BUSOFF_LIMIT)
      begin
        busoff_ff           <= 1'b1;
        busoff_hold_flag_ff <= ctrl_ff[cbt_pkg::CTRL_BORSEL]; // RULE1
      end
      else if (wr_acc && paddr == cbt_pkg::OFS_MISC && pwdata[0] &&
               busoff_hold_flag_ff)
      begin
        busoff_hold_flag_ff <= 1'b0; // RULE17
        busoff_ff           <= 1'b0; // RULE17
      end
      else if (busoff_ff && !ctrl_ff[cbt_pkg::CTRL_BORSEL])
        busoff_ff <= 1'b0;
    end
  end

  // Receive error counter, saturating
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rx_error_count_ff <= 8'h00;
    else if (ce)
    begin
      if (rx_err_clr || mode_ff == cbt_pkg::CBT_DISABLED)
        rx_error_count_ff <= 8'h00;
      else if (rx_err_inc && rx_error_count_ff != 8'hFF)
        rx_error_count_ff <= rx_error_count_ff + 8'h01; // RULE2
    end
  end

  // Sticky interrupt status; a read clears, a new event wins
  assign irq_set = {bev.sample_point, rx_err_inc, busoff_event}; // RULE13

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_st_ff <= '0;
    else if (ce)
    begin
      if (rd_acc && paddr == cbt_pkg::OFS_IRQST)
        irq_st_ff <= irq_set;
      else
        irq_st_ff <= irq_st_ff | irq_set;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_ff <= 1'b0;
    else if (ce)
      irq_ff <= |(irq_st_ff & irq_msk_ff);
  end

  // Transmit: recessive unless enabled in normal mode and not bus-off, launched at tx point
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      can_tx_ff <= 1'b1;
    else if (ce)
    begin
      if (!run_timer || busoff_ff || !ctrl_ff[cbt_pkg::CTRL_TXEN])
        can_tx_ff <= 1'b1;
      else if (bev.tx_point)
        can_tx_ff <= ctrl_ff[cbt_pkg::CTRL_TXBIT]; // RULE4
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sample_bit_ff <= 1'b1;
    else if (ce && bev.sample_point)
      sample_bit_ff <= bev.rx_bit; // RULE5
  end

  // APB: one wait state, reads registered
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !addr_ok(paddr);
      prdata_ff  <= 32'h0000_0000;
      if (psel && penable && !pready_ff && !pwrite)
      begin
        unique case (paddr)
          cbt_pkg::OFS_BTR0:   prdata_ff <= {24'h000000, btr0_ff};
          cbt_pkg::OFS_BTR1:   prdata_ff <= {24'h000000, btr1_ff};
          cbt_pkg::OFS_CTRL:   prdata_ff <= {25'h0000000, ctrl_ff};
          cbt_pkg::OFS_STAT:   prdata_ff <= {26'h0000000, busoff_ff,
                                             sleep_acknowledge_ff, 1'b0, mode_ff};
          cbt_pkg::OFS_MISC:   prdata_ff <= {31'h00000000, busoff_hold_flag_ff}; // RULE1
          cbt_pkg::OFS_RXERR:  prdata_ff <= {24'h000000, rx_error_count_ff}; // RULE2
          cbt_pkg::OFS_IRQST:  prdata_ff <= {29'h00000000, irq_st_ff};
          cbt_pkg::OFS_IRQMSK: prdata_ff <= {29'h00000000, irq_msk_ff};
          default:             prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign can_tx     = can_tx_ff;
  assign irq        = irq_ff;
  assign sample_bit = sample_bit_ff;
  assign mode_out   = mode_ff;
endmodule : cbt_top
